// ---- core/pwit_params.svh ----
`ifndef PWIT_PARAMS_SVH
`define PWIT_PARAMS_SVH

// byte read addresses and the shared word write address
`define PWIT_ADDR_CSR_RD  16'hFFA8
`define PWIT_ADDR_CNT_RD  16'hFFA9
`define PWIT_ADDR_WR      16'hFFAA

// password in the upper byte of a word write
`define PWIT_PW_COUNT     8'h5A
`define PWIT_PW_CSR       8'hA5

// control/status field positions
`define PWIT_BIT_OVF      7
`define PWIT_BIT_MODE     6
`define PWIT_BIT_RUN      5
`define PWIT_BIT_RSTSEL   3
`define PWIT_CKS_HI       2

// reset values and counter maximum
`define PWIT_CSR_RESET    8'h10
`define PWIT_CNT_RESET    8'h00
`define PWIT_CNT_MAX      8'hFF

// internal chip reset length in system clocks and hold counter width
`define PWIT_RESET_CYCLES 518
`define PWIT_HOLD_W       10

// prescaler width and tap masks (divisor minus one)
`define PWIT_PRESC_W      12
`define PWIT_MASK_DIV2    12'h001
`define PWIT_MASK_DIV32   12'h01F
`define PWIT_MASK_DIV64   12'h03F
`define PWIT_MASK_DIV128  12'h07F
`define PWIT_MASK_DIV256  12'h0FF
`define PWIT_MASK_DIV512  12'h1FF
`define PWIT_MASK_DIV2048 12'h7FF
`define PWIT_MASK_DIV4096 12'hFFF

`endif

// ---- core/pwit_pkg.sv ----
`include "pwit_params.svh"

package pwit_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        word;
  } pwit_bus_req_s;

  typedef struct packed {
    logic [7:0] count;
    logic       ovf;
    logic       ovf_seen;
    logic       mode;
    logic       run;
    logic       rst_sel;
    logic [2:0] cks;
    logic [7:0] rdata;
    logic       irq;
    logic       nmi;
    logic       wd_fire;
    logic       cause;
  } pwit_state_s;

  typedef struct packed {
    logic [`PWIT_PRESC_W-1:0] cnt;
    logic                     tick;
  } pwit_presc_s;

  typedef struct packed {
    logic [`PWIT_HOLD_W-1:0] cnt;
    logic                    active;
  } pwit_hold_s;

endpackage

// ---- core/pwit_prescaler.sv ----
`timescale 1ns/10ps
`include "pwit_params.svh"

module pwit_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] sel,
  output logic            tick
);
  import pwit_pkg::*;

  pwit_presc_s              st;
  pwit_presc_s              next_st;
  logic [`PWIT_PRESC_W-1:0] mask;

  always_comb begin
    case (sel)
      3'h0:    mask = `PWIT_MASK_DIV2;
      3'h1:    mask = `PWIT_MASK_DIV32;
      3'h2:    mask = `PWIT_MASK_DIV64;
      3'h3:    mask = `PWIT_MASK_DIV128;
      3'h4:    mask = `PWIT_MASK_DIV256;
      3'h5:    mask = `PWIT_MASK_DIV512;
      3'h6:    mask = `PWIT_MASK_DIV2048;
      default: mask = `PWIT_MASK_DIV4096;
    endcase
  end

  // free-running, so a tap change mid-count may give a short period
  always_comb begin
    next_st      = st;
    next_st.cnt  = `PWIT_PRESC_W'(st.cnt + 1'b1);
    next_st.tick = ((st.cnt & mask) == mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

// ---- core/pwit_reset_hold.sv ----
`timescale 1ns/10ps
`include "pwit_params.svh"

module pwit_reset_hold #(
  parameter int unsigned CYCLES = `PWIT_RESET_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      active
);
  import pwit_pkg::*;

  pwit_hold_s st;
  pwit_hold_s next_st;

  always_comb begin
    next_st = st;
    if (start && !st.active) begin
      next_st.active = 1'b1;
      next_st.cnt    = `PWIT_HOLD_W'(CYCLES - 1);
    end else if (st.active) begin
      if (st.cnt == '0) begin
        next_st.active = 1'b0;
      end else begin
        next_st.cnt = `PWIT_HOLD_W'(st.cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign active = st.active;
endmodule

// ---- core/pwit_top.sv ----
`timescale 1ns/10ps
`include "pwit_params.svh"

// Behaviour
// - 8-bit counter counts selected clock while running
// - wrap from max to zero sets overflow flag
// - stopped counter held at zero; zero after reset
// - flag clears by write 0 after read 1
// - mode bit picks interval or watchdog action
// - action bit picks interrupt or chip reset
// - control/status bit 4 reads one, ignores writes
// - three select bits pick prescaler divisor
// - standby clears bits 7-5,3; keeps bits 2-0
// - only word writes update either register
// - upper byte password steers shared write address
// - byte reads at two separate addresses
// - watchdog reset holds chip for 518 clocks
// - watchdog interrupt shares external pin vector
// - watchdog reset recorded in reset cause bit
// - interval mode requests interrupt every overflow
// - flag set with the request, same cycle
// - write beats coinciding count pulse
module pwit_top (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire pwit_pkg::pwit_bus_req_s bus_req,
  input  wire logic                   standby,
  output logic [7:0]                  bus_rdata,
  output logic                        irq_ovf,
  output logic                        nmi_req,
  output logic                        chip_reset,
  output logic                        reset_cause_bit
);
  import pwit_pkg::*;

  pwit_state_s st;
  pwit_state_s next_st;
  logic        tick;
  logic        wr_hit;
  logic        wr_cnt;
  logic        wr_csr;
  logic        ovf_evt;
  logic [7:0]  wr_byte;

  pwit_prescaler u_presc (
    .clk   (clk),
    .rst_n (rst_n),
    .sel   (st.cks),
    .tick  (tick)
  );

  pwit_reset_hold #(
    .CYCLES (`PWIT_RESET_CYCLES)
  ) u_hold (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (st.wd_fire),
    .active (chip_reset)
  );

  // byte writes never reach the registers
  assign wr_hit  = bus_req.wr && bus_req.word &&
                   (bus_req.addr == `PWIT_ADDR_WR);
  assign wr_cnt  = wr_hit &&
                   (bus_req.wdata[15:8] == `PWIT_PW_COUNT);
  assign wr_csr  = wr_hit &&
                   (bus_req.wdata[15:8] == `PWIT_PW_CSR);
  assign wr_byte = bus_req.wdata[7:0];

  // a write in the same cycle as a pulse drops that increment
  assign ovf_evt = st.run && tick && !wr_cnt && !standby &&
                   !chip_reset && (st.count == `PWIT_CNT_MAX);

  always_comb begin
    next_st         = st;
    next_st.irq     = 1'b0;
    next_st.nmi     = 1'b0;
    next_st.wd_fire = 1'b0;

    if (!st.run) begin
      next_st.count = `PWIT_CNT_RESET;
    end else if (wr_cnt) begin
      next_st.count = wr_byte;
    end else if (tick) begin
      next_st.count = 8'(st.count + 8'h01);
    end

    if (wr_csr) begin
      next_st.mode    = wr_byte[`PWIT_BIT_MODE];
      next_st.run     = wr_byte[`PWIT_BIT_RUN];
      next_st.rst_sel = wr_byte[`PWIT_BIT_RSTSEL];
      next_st.cks     = wr_byte[`PWIT_CKS_HI:0];
      if (!wr_byte[`PWIT_BIT_OVF] && st.ovf_seen) begin
        next_st.ovf      = 1'b0;
        next_st.ovf_seen = 1'b0;
      end
    end

    if (bus_req.rd) begin
      case (bus_req.addr)
        `PWIT_ADDR_CSR_RD: begin
          next_st.rdata = `PWIT_CSR_RESET;
          next_st.rdata[`PWIT_BIT_OVF]    = st.ovf;
          next_st.rdata[`PWIT_BIT_MODE]   = st.mode;
          next_st.rdata[`PWIT_BIT_RUN]    = st.run;
          next_st.rdata[`PWIT_BIT_RSTSEL] = st.rst_sel;
          next_st.rdata[`PWIT_CKS_HI:0]   = st.cks;
          if (st.ovf) begin
            next_st.ovf_seen = 1'b1;
          end
        end
        `PWIT_ADDR_CNT_RD: begin
          next_st.rdata = st.count;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    // set wins over a clear in the same cycle
    if (ovf_evt) begin
      next_st.ovf = 1'b1;
      if (!st.mode) begin
        next_st.irq = 1'b1;
      end else if (st.rst_sel) begin
        next_st.wd_fire = 1'b1;
        next_st.cause   = 1'b1;
      end else begin
        next_st.nmi = 1'b1;
      end
    end

    if (standby) begin
      next_st.ovf      = 1'b0;
      next_st.ovf_seen = 1'b0;
      next_st.mode     = 1'b0;
      next_st.run      = 1'b0;
      next_st.rst_sel  = 1'b0;
      next_st.count    = `PWIT_CNT_RESET;
    end

    // the chip reset we raise also clears us; only the cause survives
    if (chip_reset) begin
      next_st       = '0;
      next_st.cause = st.cause;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus_rdata       = st.rdata;
  assign irq_ovf         = st.irq;
  assign nmi_req         = st.nmi;
  assign reset_cause_bit = st.cause;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence fire_seq;
    st.wd_fire ##1 chip_reset;
  endsequence

  // reads during our own chip reset are lost, so checks skip them
  sequence csr_read_seq;
    bus_req.rd && !chip_reset && (bus_req.addr == `PWIT_ADDR_CSR_RD);
  endsequence

  sequence flag_read_seq;
    csr_read_seq ##0 (st.ovf && !wr_csr && !standby);
  endsequence

  sequence wr_count_seq;
    st.run && wr_cnt && !standby && !chip_reset;
  endsequence

  count_hold_a: assert property (
    !st.run && !wr_cnt |=> st.count == `PWIT_CNT_RESET)
    else $error("counter not zero while stopped");

  count_step_a: assert property (
    st.run && tick && !wr_cnt && !standby && !chip_reset
    |=> st.count == 8'($past(st.count) + 8'h01))
    else $error("counter did not advance on pulse");

  write_wins_a: assert property (
    st.run && wr_cnt && tick && !standby && !chip_reset
    |=> st.count == $past(wr_byte))
    else $error("count pulse beat a counter write");

  flag_set_a: assert property (
    ovf_evt |=> st.ovf)
    else $error("overflow did not set flag");

  flag_guard_a: assert property (
    wr_csr && st.ovf && !st.ovf_seen && !standby && !chip_reset
    |=> st.ovf)
    else $error("flag cleared without prior read");

  flag_no_set_a: assert property (
    wr_csr && wr_byte[`PWIT_BIT_OVF] && !st.ovf && !ovf_evt
    |=> !st.ovf)
    else $error("written one set the flag");

  interval_irq_a: assert property (
    ovf_evt && !st.mode |=> irq_ovf && !nmi_req && !st.wd_fire)
    else $error("interval overflow gave wrong request");

  watch_nmi_a: assert property (
    ovf_evt && st.mode && !st.rst_sel |=> nmi_req && !irq_ovf)
    else $error("watchdog interrupt not raised");

  req_flag_a: assert property (
    irq_ovf || nmi_req || st.wd_fire |-> st.ovf)
    else $error("request without overflow flag");

  hold_len_a: assert property (
    fire_seq |-> ##[517:517] chip_reset ##1 !chip_reset)
    else $error("chip reset not 518 clocks");

  cause_set_a: assert property (
    st.wd_fire |-> reset_cause_bit ##1 reset_cause_bit)
    else $error("reset cause not recorded");

  bit4_read_a: assert property (
    csr_read_seq |=> bus_rdata[4])
    else $error("reserved bit read as zero");

  cnt_read_a: assert property (
    bus_req.rd && !chip_reset && (bus_req.addr == `PWIT_ADDR_CNT_RD)
    |=> bus_rdata == $past(st.count))
    else $error("counter read returned wrong value");

  byte_wr_a: assert property (
    bus_req.wr && !bus_req.word && !standby && !chip_reset
    |=> $stable(st.cks) && $stable(st.mode))
    else $error("byte write changed control");

  standby_keep_a: assert property (
    standby && !chip_reset |=> !st.run && !st.ovf && $stable(st.cks))
    else $error("standby handling of control bits wrong");

  tick_single_a: assert property (
    tick |=> !tick)
    else $error("count pulse longer than one cycle");

  // reset clears count and pulse together, so skip the first edge
  div2_a: assert property (
    $past(rst_n) && !tick && (st.cks == 3'h0) && $past(st.cks == 3'h0)
    |=> tick)
    else $error("divide by two tap missed a pulse");

  cnt_wr_a: assert property (
    wr_count_seq |=> st.count == $past(wr_byte))
    else $error("counter write did not land");

  csr_wr_a: assert property (
    wr_csr && !standby && !chip_reset
    |=> st.cks == $past(wr_byte[`PWIT_CKS_HI:0]) &&
        st.run == $past(wr_byte[`PWIT_BIT_RUN]))
    else $error("control write did not land");

  wrong_pw_a: assert property (
    wr_hit && !wr_cnt && !wr_csr && !standby && !chip_reset
    |=> $stable(st.cks) && $stable(st.run) && $stable(st.mode))
    else $error("write without password changed control");

  byte_cnt_a: assert property (
    bus_req.wr && !bus_req.word && st.run && !tick && !standby &&
    !chip_reset |=> $stable(st.count))
    else $error("byte write changed counter");

  ctl_keep_a: assert property (
    !wr_csr && !standby && !chip_reset
    |=> $stable(st.mode) && $stable(st.rst_sel))
    else $error("mode changed without control write");

  wd_fire_a: assert property (
    ovf_evt && st.mode && st.rst_sel
    |=> st.wd_fire && !nmi_req && !irq_ovf)
    else $error("watchdog reset not requested");

  req_excl_a: assert property (
    irq_ovf |-> !nmi_req && !st.wd_fire)
    else $error("interval and watchdog requests together");

  irq_pulse_a: assert property (
    irq_ovf |=> !irq_ovf)
    else $error("overflow interrupt longer than one cycle");

  nmi_pulse_a: assert property (
    nmi_req |=> !nmi_req)
    else $error("watchdog interrupt longer than one cycle");

  wrap_zero_a: assert property (
    ovf_evt |=> st.count == 8'h00)
    else $error("counter did not wrap to zero");

  hold_start_a: assert property (
    st.wd_fire |=> chip_reset)
    else $error("chip reset did not start");

  reset_start_a: assert property (
    $rose(chip_reset) |-> $past(st.wd_fire))
    else $error("chip reset without watchdog overflow");

  reset_clr_a: assert property (
    chip_reset |=> !st.run && !st.ovf && st.count == 8'h00)
    else $error("chip reset left state behind");

  cause_keep_a: assert property (
    reset_cause_bit |=> reset_cause_bit)
    else $error("reset cause lost");

  standby_clr_a: assert property (
    standby && !chip_reset
    |=> st.count == 8'h00 && !st.mode && !st.rst_sel)
    else $error("standby left counter or mode set");

  csr_read_a: assert property (
    csr_read_seq |=> bus_rdata[`PWIT_BIT_OVF] == $past(st.ovf) &&
                     bus_rdata[`PWIT_CKS_HI:0] == $past(st.cks))
    else $error("control read returned wrong value");

  rd_unmap_a: assert property (
    bus_req.rd && !chip_reset && (bus_req.addr != `PWIT_ADDR_CSR_RD) &&
    (bus_req.addr != `PWIT_ADDR_CNT_RD) |=> bus_rdata == 8'h00)
    else $error("unmapped read returned data");

  rdata_hold_a: assert property (
    !bus_req.rd && !chip_reset |=> $stable(bus_rdata))
    else $error("read data changed without a read");

  flag_clear_a: assert property (
    wr_csr && !wr_byte[`PWIT_BIT_OVF] && st.ovf_seen && !ovf_evt
    |=> !st.ovf)
    else $error("flag not cleared after read");

  flag_arm_a: assert property (
    flag_read_seq |=> st.ovf_seen)
    else $error("flag read did not arm clear");
endmodule

// ---- tb/pwit_cpu_model.sv ----
`timescale 1ns/10ps
`include "pwit_params.svh"

module pwit_cpu_model (
  input  wire logic                   clk,
  input  wire logic [7:0]             bus_rdata,
  output pwit_pkg::pwit_bus_req_s     bus_req
);
  import pwit_pkg::*;

  initial bus_req = '0;

  // word write to the shared address; word=0 only to probe refusal
  task automatic wr(input logic [15:0] d, input logic w);
    @(negedge clk);
    bus_req.addr  = `PWIT_ADDR_WR;
    bus_req.wdata = d;
    bus_req.word  = w;
    bus_req.wr    = 1'b1;
    @(negedge clk);
    bus_req.wr    = 1'b0;
    // released bus lines must not keep the last value
    bus_req.addr  = ~bus_req.addr;
    bus_req.wdata = ~bus_req.wdata;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    @(negedge clk);
    bus_req.addr = a;
    bus_req.word = 1'b0;
    bus_req.rd   = 1'b1;
    @(negedge clk);
    bus_req.rd   = 1'b0;
    @(negedge clk);
    q = bus_rdata;
    bus_req.addr = ~bus_req.addr;
  endtask
endmodule

// ---- tb/pwit_tb_top.sv ----
`timescale 1ns/10ps

module pwit_tb_top;
  import pwit_pkg::*;

  logic          clk     = 1'b0;
  logic          rst_n   = 1'b0;
  logic          standby = 1'b0;
  pwit_bus_req_s bus_req;
  logic [7:0]    bus_rdata;
  logic [7:0]    q;
  logic [2:0]    c;
  logic          irq_ovf;
  logic          nmi_req;
  logic          chip_reset;
  logic          reset_cause_bit;
  int            n_fail   = 0;
  int            compares = 0;
  int            cyc      = 0;
  int            t0;
  int            t1;
  int            k;
  int            div [8]  = '{2, 32, 64, 128, 256, 512, 2048, 4096};

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  pwit_top i_pwit_top (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .standby(standby), .bus_rdata(bus_rdata), .irq_ovf(irq_ovf),
    .nmi_req(nmi_req), .chip_reset(chip_reset),
    .reset_cause_bit(reset_cause_bit));

  pwit_cpu_model i_pwit_cpu_model (.clk(clk), .bus_rdata(bus_rdata),
    .bus_req(bus_req));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic w(input logic [15:0] d);
    i_pwit_cpu_model.wr(d, 1'b1);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    i_pwit_cpu_model.rd(a, q);
    chk({8'h00, q}, {8'h00, e});
  endtask

  // sel 0 interval request, 1 interrupt, 2 chip reset; bounded wait
  task automatic wait_ev(input int sel, input int lim);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (!(sel == 0 ? irq_ovf === 1'b1 : sel == 1 ?
                 nmi_req === 1'b1 : chip_reset === 1'b1) && k < lim);
    chk(16'(k < lim), 16'h0001);
    t1 = cyc;
  endtask

  task automatic test_done;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rdc(16'hFFA8, 8'h10);
    rdc(16'hFFA9, 8'h00);
    i_pwit_cpu_model.wr(16'hA52F, 1'b0);
    w(16'h552F);
    rdc(16'hFFA8, 8'h10);
    rdc(16'hFFAB, 8'h00);
    $display("test reset_and_refusal done");
    for (int s = 0; s < 8; s++) begin
      c = 3'(s);
      w({8'hA5, 5'h00, c}); // stop and change select in one write
      w({8'hA5, 5'h14, c});
      rdc(16'hFFA8, {5'h06, c});
      w(16'h5AFD);
      wait_ev(0, 5 * div[s]);
      t0 = t1;
      // flag not yet read as one, so this clear is ignored
      w({8'hA5, 5'h04, c});
      rdc(16'hFFA8, {5'h16, c});
      w({8'hA5, 5'h04, c});
      rdc(16'hFFA8, {5'h06, c});
      if (s != 0) begin
        rdc(16'hFFA9, 8'h00);
        w(16'h5AFD);
      end
      wait_ev(0, 5 * div[s] + 600);
      chk(16'(t1 - t0), s == 0 ? 16'h0200 : 16'(3 * div[s]));
      rdc(16'hFFA8, {5'h16, c});
      w({8'hA5, 5'h04, c});
    end
    $display("test interval_divisors done");
    w(16'hA501);
    w(16'hA561);
    w(16'h5AFD);
    i_pwit_cpu_model.wr(16'h5A00, 1'b0);
    wait_ev(1, 200);
    chk({15'h0000, irq_ovf}, 16'h0000);
    $display("test watchdog_interrupt done");
    w(16'hA501);
    w(16'hA569);
    w(16'h5AFD);
    wait_ev(2, 200);
    t0 = t1;
    chk({15'h0000, reset_cause_bit}, 16'h0001);
    while (chip_reset === 1'b1 && cyc - t0 < 600) @(negedge clk);
    chk(16'(cyc - t0), 16'h0206);
    rdc(16'hFFA8, 8'h10);
    $display("test watchdog_reset done");
    w(16'hA52B);
    standby = 1'b1;
    repeat (3) @(negedge clk);
    standby = 1'b0;
    rdc(16'hFFA8, 8'h13);
    rdc(16'hFFA9, 8'h00);
    $display("test standby done");
    test_done;
  end

  // tests need about 42k cycles
  initial begin
    #(90000 * 8);
    n_fail++;
    test_done;
  end
endmodule
